// ---- rtl/pdt_regs.svh ----
// Register map, field positions, reset values and timing counts of the
// prescaled down timer.
// Assumes APB byte addressing with one 32-bit word per register.
`ifndef PDT_REGS_SVH
`define PDT_REGS_SVH

// ****************************************************************
// Register word offsets (byte address = index * 4)
// ****************************************************************
`define PDT_IDX_CTRL 12'h009
`define PDT_IDX_COUNT 12'h008
`define PDT_IDX_IRQ_STAT 12'h00A
`define PDT_IDX_IRQ_MASK 12'h00B
`define PDT_IDX_SEC_IRQ 12'h00C
`define PDT_ADDR_CTRL (`PDT_IDX_CTRL * 4)
`define PDT_ADDR_COUNT (`PDT_IDX_COUNT * 4)
`define PDT_ADDR_IRQ_STAT (`PDT_IDX_IRQ_STAT * 4)
`define PDT_ADDR_IRQ_MASK (`PDT_IDX_IRQ_MASK * 4)
`define PDT_ADDR_SEC_IRQ (`PDT_IDX_SEC_IRQ * 4)

// ****************************************************************
// Control register fields
// ****************************************************************
`define PDT_CTRL_REQ 7
`define PDT_CTRL_MASK 6
`define PDT_CTRL_PSC_CLR 3
`define PDT_CTRL_UNUSED 8'h37
`define PDT_CTRL_RESET 8'h40

// ****************************************************************
// Interrupt status and mask fields
// ****************************************************************
`define PDT_STAT_ZERO 0
`define PDT_STAT_SEC 1

// ****************************************************************
// Timing
// ****************************************************************
`define PDT_PIN_CYCLES 3
`define PDT_PHI2_DIV 4

`endif

// ---- rtl/pdt_pkg.sv ----
// Types shared by the prescaled down timer modules.
// Assumes nothing of its surroundings.
package pdt_pkg;
  // Count clock source, fixed at build time
  typedef enum logic {
    PDT_SRC_PHI2,
    PDT_SRC_PIN
  } pdt_src_t;
endpackage

// ---- rtl/pdt_tick_if.sv ----
// Interface carrying the count tick from the prescaler to the counter.
// Assumes one clock, pclk.
`timescale 1ns/1ps
`default_nettype none
interface pdt_tick_if;
  logic tick;
  logic clear;
  modport src (output tick, input clear);
  modport dst (input tick, output clear);
endinterface
`default_nettype wire

// ---- rtl/pdt_prescaler.sv ----
// Count source selection, pin sampling delay and 7-bit prescaler.
// Assumes timer_pin is synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
`include "pdt_regs.svh"
module pdt_prescaler #(
  parameter pdt_pkg::pdt_src_t SRC = pdt_pkg::PDT_SRC_PHI2,
  parameter int DIV_LOG2 = 7
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic timer_pin,
  pdt_tick_if.src tk
);
  logic [`PDT_PIN_CYCLES-1:0] pin_pipe;
  logic [1:0] phi2_cnt;
  logic [6:0] presc;
  logic src_pulse;
  logic [6:0] presc_max;

  // Pin delay line; a change takes three cycles to reach the prescaler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_pipe <= '0;
    end else begin
      pin_pipe <= {pin_pipe[`PDT_PIN_CYCLES-2:0], timer_pin};
    end
  end

  // Internal phase-two rate derived from pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phi2_cnt <= 2'h0;
    end else begin
      phi2_cnt <= phi2_cnt + 2'h1;
    end
  end

  // Source fixed at build time; pin counts its rising edges
  always_comb begin
    if (SRC == pdt_pkg::PDT_SRC_PIN) begin
      src_pulse = pin_pipe[`PDT_PIN_CYCLES-1] &
                  !pin_pipe[`PDT_PIN_CYCLES-2] ? 1'b0 :
                  pin_pipe[`PDT_PIN_CYCLES-2] &
                  !pin_pipe[`PDT_PIN_CYCLES-1];
    end else begin
      src_pulse = (phi2_cnt == 2'h3);
    end
  end

  // Divide ratio is a power of two up to 128
  assign presc_max = 7'((1 << DIV_LOG2) - 1);

  // Prescaler; clear wins to avoid a truncated first period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc <= 7'h00;
      tk.tick <= 1'b0;
    end else if (tk.clear) begin
      presc <= 7'h00;
      tk.tick <= 1'b0;
    end else if (src_pulse) begin
      presc <= (presc >= presc_max) ? 7'h00 : presc + 7'h01;
      tk.tick <= (presc >= presc_max);
    end else begin
      tk.tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/pdt_core_irq.sv ----
// Interrupt arbiter toward the processor core.
// Assumes the core gives its global mask level and takes one request.
`timescale 1ns/1ps
`default_nettype none
module pdt_core_irq (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ext_pending,
  input wire logic timer_pending,
  input wire logic global_mask,
  output logic ext_take,
  output logic timer_take
);
  // External first; nothing while the core's global mask is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_take <= 1'b0;
      timer_take <= 1'b0;
    end else begin
      ext_take <= ext_pending & !global_mask;
      timer_take <= timer_pending & !global_mask & !ext_pending;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/pdt_timer.sv ----
// Prescaled 8-bit down timer with APB register access.
// Assumes one 100 MHz pclk and inputs synchronous to it.
//
// Notes on behaviour
// - Loadable 8-bit down counter fed by prescaler.
// - Reaching zero sets request flag, control bit 7.
// - Control bit 6 masks timer interrupt.
// - Interrupt delivered only with core mask clear.
// - Flag clears on reset or software write.
// - Writing bit 3 clears prescaler; reads zero.
// - Counter wraps from zero to all ones.
// - Count readable anytime without disturbing it.
// - Pin change reaches prescaler in three cycles.
// - Count source fixed at build time.
// - Prescale ratio power of two, up to 128.
// - Unused control bits ignored, read as ones.
// - Unmasked request on each one-to-zero step.
// - Masked request latched; cleared flag means none.
// - External interrupt served before timer.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "pdt_regs.svh"
module pdt_timer #(
  parameter pdt_pkg::pdt_src_t SRC = pdt_pkg::PDT_SRC_PHI2,
  parameter int DIV_LOG2 = 7
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_pin,
  input wire logic secondary_irq_pin,
  input wire logic global_mask,
  output logic irq,
  output logic timer_take,
  output logic ext_take
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  pdt_tick_if tk ();
  logic [7:0] timer_count_reg;
  logic timer_request_flag;
  logic timer_irq_mask;
  logic sec_flag;
  logic sec_pin_d;
  logic [1:0] irq_stat;
  logic [1:0] irq_en;
  logic wr;
  logic zero_event;
  logic sec_event;
  logic hit;
  logic [31:0] next_prdata;

  // Address decode shared by read and write paths
  function automatic logic known(input logic [11:0] a);
    known = (a == `PDT_ADDR_CTRL) || (a == `PDT_ADDR_COUNT) ||
            (a == `PDT_ADDR_IRQ_STAT) || (a == `PDT_ADDR_IRQ_MASK) ||
            (a == `PDT_ADDR_SEC_IRQ);
  endfunction

  // ****************************************************************
  // APB access
  // ****************************************************************
  // Access phase lasts one cycle: pready is high in every access phase
  assign wr = psel & penable & pwrite;
  assign hit = known(paddr);

  // Prescaler with its delay line and source option
  pdt_prescaler #(
    .SRC(SRC),
    .DIV_LOG2(DIV_LOG2)
  ) u_presc (
    .pclk(pclk),
    .presetn(presetn),
    .timer_pin(timer_pin),
    .tk(tk)
  );

  // Prescaler clear is a pulse; nothing stores bit 3
  assign tk.clear = wr & (paddr == `PDT_ADDR_CTRL) &
                    pwdata[`PDT_CTRL_PSC_CLR];

  // ****************************************************************
  // Counter
  // ****************************************************************
  // Step from one to zero marks the timer event
  assign zero_event = tk.tick & (timer_count_reg == 8'h01) &
                      !(wr & (paddr == `PDT_ADDR_COUNT));

  // Load has priority over a tick in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_count_reg <= 8'hFF;
    end else if (wr && paddr == `PDT_ADDR_COUNT) begin
      timer_count_reg <= pwdata[7:0];
    end else if (tk.tick) begin
      timer_count_reg <= timer_count_reg - 8'h01;
    end
  end

  // ****************************************************************
  // Control register
  // ****************************************************************
  // Request flag: set wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_request_flag <= 1'b0;
    end else if (zero_event) begin
      timer_request_flag <= 1'b1;
    end else if (wr && paddr == `PDT_ADDR_CTRL) begin
      timer_request_flag <= pwdata[`PDT_CTRL_REQ];
    end
  end

  // Mask resets set, so the timer request cannot fire before software enables it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_irq_mask <= 1'b1;
    end else if (wr && paddr == `PDT_ADDR_CTRL) begin
      timer_irq_mask <= pwdata[`PDT_CTRL_MASK];
    end
  end

  // ****************************************************************
  // Secondary interrupt flag sharing the timer vector
  // ****************************************************************
  assign sec_event = sec_pin_d & !secondary_irq_pin;

  // Falling edge latches the flag; software clears by writing one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_pin_d <= 1'b1;
      sec_flag <= 1'b0;
    end else begin
      sec_pin_d <= secondary_irq_pin;
      if (sec_event) begin
        sec_flag <= 1'b1;
      end else if (wr && paddr == `PDT_ADDR_SEC_IRQ && pwdata[0]) begin
        sec_flag <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************
  // Sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == `PDT_STAT_ZERO) ? zero_event : sec_event) begin
          irq_stat[i] <= 1'b1;
        end else if (wr && paddr == `PDT_ADDR_IRQ_STAT && pwdata[i]) begin
          irq_stat[i] <= 1'b0;
        end
      end
    end
  end

  // Enable register of the same layout
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en <= 2'h0;
    end else if (wr && paddr == `PDT_ADDR_IRQ_MASK) begin
      irq_en <= pwdata[1:0];
    end
  end

  // Level interrupt from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_en);
    end
  end

  // Core-side arbitration of the two shared-vector sources
  pdt_core_irq u_core (
    .pclk(pclk),
    .presetn(presetn),
    .ext_pending(sec_flag),
    .timer_pending(timer_request_flag & !timer_irq_mask),
    .global_mask(global_mask),
    .ext_take(ext_take),
    .timer_take(timer_take)
  );

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Reads have no side effect, so counting never pauses
  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      `PDT_ADDR_CTRL: begin
        next_prdata[7:0] = {timer_request_flag, timer_irq_mask, 6'h00} |
                           `PDT_CTRL_UNUSED;
      end
      `PDT_ADDR_COUNT: begin
        next_prdata[7:0] = timer_count_reg;
      end
      `PDT_ADDR_IRQ_STAT: begin
        next_prdata[1:0] = irq_stat;
      end
      `PDT_ADDR_IRQ_MASK: begin
        next_prdata[1:0] = irq_en;
      end
      `PDT_ADDR_SEC_IRQ: begin
        next_prdata[0] = sec_flag;
      end
      default: begin
        next_prdata = 32'h0000_0000;
      end
    endcase
  end

  // Registered answer, ready in the access phase's cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= (psel & !penable & !pwrite) ? next_prdata : prdata;
      pready <= psel & !penable;
      pslverr <= psel & !penable & !hit;
    end
  end
endmodule
`default_nettype wire

// ---- sim/pdt_core_model.sv ----
// Core model: takes timer and external requests like the processor.
// Assumes pdt_timer outputs; rti comes from the bench handler.
`timescale 1ns/1ps
`default_nettype none
module pdt_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hold,
  input wire logic rti,
  input wire logic timer_take,
  input wire logic ext_take,
  output logic global_mask,
  output logic [7:0] n_ext,
  output logic [7:0] n_tim
);
  // ****
  // Entry
  // ****
  logic busy;
  // I bit: set while a handler runs, or held by the bench
  assign global_mask = hold | busy;
  // One entry per request; busy hides the late registered take
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      n_ext <= 8'h00;
      n_tim <= 8'h00;
    end else if (rti) begin
      busy <= 1'b0;
    end else if (!global_mask && ext_take) begin
      busy <= 1'b1;
      n_ext <= n_ext + 8'h01;
    end else if (!global_mask && timer_take) begin
      busy <= 1'b1;
      n_tim <= n_tim + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ---- sim/pdt_timer_asserts.sv ----
// Port checker for pdt_timer, bound below.
// Assumes pdt_regs.svh on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "pdt_regs.svh"
module pdt_timer_asserts #(
  parameter int DIV_LOG2 = 7
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic global_mask,
  input wire logic irq,
  input wire logic timer_take,
  input wire logic ext_take
);
  // ****
  // Checks
  // ****
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mapped;
  logic wr;
  // Decode of the five registers
  assign mapped = paddr inside {12'(`PDT_ADDR_CTRL), 12'(`PDT_ADDR_COUNT),
    12'(`PDT_ADDR_IRQ_STAT), 12'(`PDT_ADDR_IRQ_MASK), 12'(`PDT_ADDR_SEC_IRQ)};
  assign wr = psel && penable && pwrite;
  chk_ready_now: assert property (psel && penable |-> pready)
    else $error("no zero-wait answer");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_unmapped: assert property (pready && !mapped |-> pslverr)
    else $error("unmapped access not refused");
  chk_err_mapped: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access refused");
  chk_ctrl_bits: assert property (
    pready && !pwrite && paddr == 12'(`PDT_ADDR_CTRL) |->
    prdata[31:8] == 24'h00_0000 && prdata[5:0] == 6'h37)
    else $error("control fixed bits wrong");
  chk_ext_first: assert property (ext_take |-> !timer_take)
    else $error("timer taken over external");
  chk_core_mask: assert property (
    global_mask |=> !timer_take && !ext_take)
    else $error("take while core masked");
  chk_irq_keep: assert property (
    irq && !wr && !$past(wr) |=> irq)
    else $error("irq dropped without write");
endmodule
bind pdt_timer pdt_timer_asserts #(.DIV_LOG2(DIV_LOG2)) i_pdt_timer_asserts (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .global_mask, .irq, .timer_take, .ext_take);
`default_nettype wire

// ---- sim/tb.sv ----
// Bench for the prescaled down timer: APB master, core model, scoreboard.
// Assumes the design and pdt_regs.svh on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "pdt_regs.svh"
module tb;
  // ****
  // Bench
  // ****
  typedef struct {logic er; logic [31:0] v; logic [31:0] m;} pdt_note_t;
  localparam logic [11:0] A_CTL = 12'(`PDT_ADDR_CTRL);
  localparam logic [11:0] A_CNT = 12'(`PDT_ADDR_COUNT);
  localparam logic [11:0] A_STA = 12'(`PDT_ADDR_IRQ_STAT);
  localparam logic [11:0] A_MSK = 12'(`PDT_ADDR_IRQ_MASK);
  localparam logic [11:0] A_SEC = 12'(`PDT_ADDR_SEC_IRQ);
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  pdt_note_t q[$];
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rti;
  logic timer_pin, secondary_irq_pin, global_mask, timer_take, ext_take;
  logic hold;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, s, d, pin_rdata;
  logic [7:0] n_ext, n_tim;
  int miscompares, n_checks;
  pdt_timer #(.DIV_LOG2(0)) i_pdt_timer (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .timer_pin,
    .secondary_irq_pin, .global_mask, .irq, .timer_take, .ext_take);
  // Pin-sourced copy dividing by two shares the bus; only its count is read
  pdt_timer #(.SRC(pdt_pkg::PDT_SRC_PIN), .DIV_LOG2(1)) i_pdt_timer_pin (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata(pin_rdata), .pready(), .pslverr(), .timer_pin,
    .secondary_irq_pin, .global_mask, .irq(), .timer_take(), .ext_take());
  pdt_core_model i_pdt_core_model (.pclk, .presetn, .hold, .rti,
    .timer_take, .ext_take, .global_mask, .n_ext, .n_tim);
  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic bus(input logic w, input logic [11:0] a,
    input logic [31:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
    input logic [31:0] m, input logic er);
    q.push_back('{er, e, m});
    bus(1'b0, a, 32'h0000_0000);
  endtask
  // Write, then look at irq once the registered level has moved
  task automatic wchk(input logic [11:0] a, input logic [31:0] v,
    input logic e);
    bus(1'b1, a, v);
    repeat (2) @(posedge pclk);
    chk("irq", {31'h0000_0000, e}, {31'h0000_0000, irq});
  endtask
  // Handler return, then wait for entry e; the watchdog bounds the wait
  task automatic ret_wait(input int e);
    rti <= 1'b1;
    @(posedge pclk);
    rti <= 1'b0;
    while (int'(n_ext) + int'(n_tim) < e) begin
      @(posedge pclk);
    end
  endtask
  // Scoreboard: each read answer retires the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && q.size() > 0) begin
      chk("rdata", q[0].v, prdata & q[0].m);
      chk("slverr", {31'h0000_0000, q[0].er}, {31'h0000_0000, pslverr});
      void'(q.pop_front());
    end
  end
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, timer_pin, hold, rti} = '0;
    secondary_irq_pin = 1'b1;
    presetn = 1'b0;
    s = 32'h0000_005F;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_CTL, 32'h0000_0077, ALL, 1'b0);
    rd(A_CNT, 32'h0000_00F8, 32'hFFFF_FFF8, 1'b0);
    rd(12'h100, 32'h0000_0000, ALL, 1'b1);
    bus(1'b1, A_CTL, 32'h0000_0048);
    rd(A_CTL, 32'h0000_0077, ALL, 1'b0);
    for (int i = 0; i < 4; i++) begin
      s = xs(s);
      d = {24'h00_0000, s[7:3], 3'h7};
      bus(1'b1, A_CNT, d);
      rd(A_CNT, d & 32'h0000_00F8, 32'hFFFF_FFF8, 1'b0);
    end
    // Pin copy: one edge, prescaler clear, then two edges for one step
    timer_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    timer_pin <= 1'b0;
    bus(1'b1, A_CTL, 32'h0000_0048);
    timer_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    timer_pin <= 1'b0;
    rd(A_CNT, 32'h0000_0000, 32'hFFFF_FF00, 1'b0);
    chk("pin count", d, pin_rdata);
    timer_pin <= 1'b1;
    rd(A_CNT, 32'h0000_0000, 32'hFFFF_FF00, 1'b0);
    chk("pin count", d, pin_rdata);
    rd(A_CNT, 32'h0000_0000, 32'hFFFF_FF00, 1'b0);
    chk("pin count", d - 32'h0000_0001, pin_rdata);
    bus(1'b1, A_CNT, 32'h0000_0002);
    repeat (20) @(posedge pclk);
    chk("n_tim", 32'h0000_0000, {24'h00_0000, n_tim});
    rd(A_CTL, 32'h0000_00F7, ALL, 1'b0);
    rd(A_CNT, 32'h0000_00F0, 32'hFFFF_FFF0, 1'b0);
    bus(1'b1, A_CTL, 32'h0000_0040);
    bus(1'b1, A_CTL, 32'h0000_0000);
    repeat (5) @(posedge pclk);
    chk("n_tim", 32'h0000_0000, {24'h00_0000, n_tim});
    wchk(A_MSK, 32'h0000_0001, 1'b1);
    wchk(A_MSK, 32'h0000_0000, 1'b0);
    wchk(A_STA, 32'h0000_0001, 1'b0);
    wchk(A_MSK, 32'h0000_0001, 1'b0);
    // Both sources pending behind the core mask
    hold <= 1'b1;
    bus(1'b1, A_CNT, 32'h0000_0001);
    repeat (12) @(posedge pclk);
    secondary_irq_pin <= 1'b0;
    repeat (6) @(posedge pclk);
    hold <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("n_ext", 32'h0000_0001, {24'h00_0000, n_ext});
    chk("n_tim", 32'h0000_0000, {24'h00_0000, n_tim});
    rd(A_CTL, 32'h0000_00B7, ALL, 1'b0);
    rd(A_SEC, 32'h0000_0001, 32'h0000_0001, 1'b0);
    bus(1'b1, A_SEC, 32'h0000_0001);
    ret_wait(2);
    chk("n_tim", 32'h0000_0001, {24'h00_0000, n_tim});
    bus(1'b1, A_CTL, 32'h0000_0000);
    ret_wait(2);
    repeat (20) @(posedge pclk);
    chk("n_tim", 32'h0000_0001, {24'h00_0000, n_tim});
    // Mid-run reset must drop a request flag that software set
    bus(1'b1, A_CTL, 32'h0000_00C0);
    rd(A_CTL, 32'h0000_00F7, ALL, 1'b0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_CTL, 32'h0000_0077, ALL, 1'b0);
    // Let the scoreboard retire the last note first
    @(posedge pclk);
    print_verdict();
  end
  // Watchdog: the sequence needs well under 5000 cycles
  initial begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    print_verdict();
  end
endmodule
`default_nettype wire
